// ===== core/kspc_pkg.sv
// Shared constants, types and decode functions for the knock processor control.
// Assumes a single 250 MHz core clock and word-level programming over the serial link.
package kspc_pkg;

  // Serial word framing.
  localparam int          WORD_W    = 8;
  localparam int          BCNT_W    = 4;
  localparam logic [3:0]  WORD_BITS = 4'h8;

  // Address prefixes and field positions.
  localparam logic [1:0]  PFX_BPF   = 2'h0;
  localparam logic [1:0]  PFX_PRE   = 2'h1;
  localparam logic [1:0]  PFX_GAIN  = 2'h2;
  localparam logic [1:0]  PFX_LONG  = 2'h3;
  localparam int          PFX_MSB   = 7;
  localparam int          PFX_LSB   = 6;
  localparam int          SUB_BIT   = 5;
  localparam int          V6_MSB    = 5;
  localparam int          V5_MSB    = 4;
  localparam int          PRE_MSB   = 4;
  localparam int          PRE_LSB   = 1;
  localparam int          Z_BIT     = 0;
  localparam int          CHAN_BIT  = 0;
  localparam int          DIAG_MSB  = 4;
  localparam int          DIAG_LSB  = 1;
  localparam int          EXT_BIT   = 3;
  localparam int          SRC_MSB   = 2;

  // Reset values of the settings.
  localparam logic [5:0]  BPF_RST   = 6'h00;
  localparam logic [5:0]  GAIN_RST  = 6'h00;
  localparam logic [4:0]  TC_RST    = 5'h00;
  localparam logic [4:0]  TEST_RST  = 5'h00;
  localparam logic [3:0]  PRE_RST   = 4'h0;
  localparam logic        Z_RST     = 1'b1;

  // Timing.
  localparam int CLK_MHZ          = 250;
  localparam int SC_RATE_KHZ      = 200;
  localparam int INT_RESET_NS     = 2000;
  localparam int INT_START_MAX_NS = 20000;
  localparam int INT_RESET_CYC    = (INT_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int PRE_CODES        = 9;
  localparam int OSC_MHZ [PRE_CODES] = '{4, 5, 6, 8, 10, 12, 16, 20, 24};

  typedef enum logic [2:0] {KSPC_WK_BPF, KSPC_WK_PRE, KSPC_WK_GAIN, KSPC_WK_TC, KSPC_WK_TEST} kspc_kind_t;
  typedef enum logic [2:0] {KSPC_SRC_RUN, KSPC_SRC_INT_POS, KSPC_SRC_INT_NEG,
                            KSPC_SRC_SCF, KSPC_SRC_GAIN, KSPC_SRC_AAF} kspc_src_t;

  // Word type from its leading address bits.
  function automatic kspc_kind_t kspc_kind(input logic [WORD_W-1:0] w);
    unique case (w[PFX_MSB:PFX_LSB])
      PFX_BPF:  kspc_kind = KSPC_WK_BPF;
      PFX_PRE:  kspc_kind = KSPC_WK_PRE;
      PFX_GAIN: kspc_kind = KSPC_WK_GAIN;
      PFX_LONG: kspc_kind = w[SUB_BIT] ? KSPC_WK_TEST : KSPC_WK_TC;
    endcase
  endfunction

  // Oscillator edges per sampling period; codes above the table act as the top entry.
  function automatic logic [7:0] kspc_ratio(input logic [3:0] code);
    int idx;
    idx = (int'(code) < PRE_CODES) ? int'(code) : PRE_CODES - 1;
    kspc_ratio = 8'(OSC_MHZ[idx] * 1000 / SC_RATE_KHZ);
  endfunction

endpackage

// ===== core/kspc_word_if.sv
// Carries one received programming word from the serial receiver to the settings logic.
// Assumes both ends run on the core clock.
interface kspc_word_if;
  import kspc_pkg::*;
  logic              word_valid;
  logic [WORD_W-1:0] word;
  logic              frame_bad;
  modport tx (output word_valid, output word, output frame_bad);
  modport rx (input word_valid, input word, input frame_bad);
endinterface

// ===== core/kspc_spi_rx.sv
// Serial receiver: samples the link pins and hands over whole eight-bit words.
// Assumes the link pins are asynchronous to the core clock and far slower than it.
module kspc_spi_rx
  import kspc_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic sck_i,
  input  wire logic cs_n_i,
  input  wire logic mosi_i,
  kspc_word_if.tx   wif
);
  logic [2:0]        sck_reg, cs_reg, sck_next, cs_next;
  logic [1:0]        mosi_reg, mosi_next;
  logic [WORD_W-1:0] shift_reg, shift_next;
  logic [BCNT_W-1:0] cnt_reg, cnt_next;
  logic              valid_reg, valid_next, bad_reg, bad_next;
  logic              sck_fall, cs_fall, cs_rise;

  // Two-stage synchronisers, third stage only for edge detection.
  assign sck_fall = ~sck_reg[1] & sck_reg[2];
  assign cs_fall  = ~cs_reg[1] & cs_reg[2];
  assign cs_rise  = cs_reg[1] & ~cs_reg[2];

  // Shift on falling clock while selected, judge length on deselect.
  always_comb begin
    sck_next   = {sck_reg[1:0], sck_i};
    cs_next    = {cs_reg[1:0], cs_n_i};
    mosi_next  = {mosi_reg[0], mosi_i};
    shift_next = shift_reg;
    cnt_next   = cnt_reg;
    valid_next = 1'b0;
    bad_next   = 1'b0;
    if (cs_fall) begin
      cnt_next = '0;
    end else if (sck_fall && !cs_reg[1]) begin
      shift_next = {shift_reg[WORD_W-2:0], mosi_reg[1]};
      if (cnt_reg <= WORD_BITS) begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
    if (cs_rise) begin
      valid_next = (cnt_reg == WORD_BITS);
      bad_next   = (cnt_reg != WORD_BITS);
    end
  end

  // Registers.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_reg   <= 3'h0;
      cs_reg    <= 3'h7;
      mosi_reg  <= 2'h0;
      shift_reg <= '0;
      cnt_reg   <= '0;
      valid_reg <= 1'b0;
      bad_reg   <= 1'b0;
    end else begin
      sck_reg   <= sck_next;
      cs_reg    <= cs_next;
      mosi_reg  <= mosi_next;
      shift_reg <= shift_next;
      cnt_reg   <= cnt_next;
      valid_reg <= valid_next;
      bad_reg   <= bad_next;
    end
  end

  assign wif.word_valid = valid_reg;
  assign wif.word       = shift_reg;
  assign wif.frame_bad  = bad_reg;

  word_length_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    valid_reg |-> $past(cnt_reg) == WORD_BITS && $past(cs_rise))
    else $error("Word handed over after a frame of wrong length.");

  idle_shift_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (cs_reg[1] && !cs_rise && !cs_fall) |=> $stable(cnt_reg))
    else $error("Bit counter moved while deselected.");
endmodule

// ===== core/kspc_int_hold.sv
// Integrate/hold sequencer: reset phase, integration and hold of the integrator.
// Assumes the integrate/hold pin is asynchronous to the core clock.
module kspc_int_hold
  import kspc_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic int_hold_i,
  output logic      integ_reset_o,
  output logic      integ_run_o,
  output logic      hold_o
);
  localparam int RST_C = INT_RESET_CYC;
  localparam int CW    = $clog2(RST_C + 1);

  typedef enum logic [1:0] {IH_HOLD, IH_RESET, IH_INTEG} kspc_ih_t;
  kspc_ih_t        st_reg, st_next;
  logic [2:0]      ih_reg, ih_next;
  logic [CW-1:0]   cnt_reg, cnt_next;
  logic            ih_rise;

  // Refuses at elaboration a reset phase that cannot end inside the integration start limit.
  if (INT_RESET_NS > INT_START_MAX_NS || RST_C < 1) begin : g_rst_chk
    $error("Integrator reset phase too long.");
  end

  assign ih_rise = ih_reg[1] & ~ih_reg[2];

  // Next state of the sequencer.
  always_comb begin
    ih_next  = {ih_reg[1:0], int_hold_i};
    st_next  = st_reg;
    cnt_next = cnt_reg;
    unique case (st_reg)
      IH_HOLD: begin
        if (ih_rise) begin
          st_next  = IH_RESET;
          cnt_next = CW'(RST_C - 1);
        end
      end
      IH_RESET: begin
        if (!ih_reg[1]) begin
          st_next = IH_HOLD;
        end else if (cnt_reg == '0) begin
          st_next = IH_INTEG;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      IH_INTEG: begin
        if (!ih_reg[1]) begin
          st_next = IH_HOLD;
        end
      end
    endcase
  end

  // Registers.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg  <= IH_HOLD;
      ih_reg  <= 3'h0;
      cnt_reg <= '0;
    end else begin
      st_reg  <= st_next;
      ih_reg  <= ih_next;
      cnt_reg <= cnt_next;
    end
  end

  assign integ_reset_o = (st_reg == IH_RESET);
  assign integ_run_o   = (st_reg == IH_INTEG);
  assign hold_o        = (st_reg == IH_HOLD);

  reset_phase_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(integ_reset_o) |-> ##[1:RST_C] !integ_reset_o)
    else $error("Integrator reset phase overran.");

  hold_entry_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(ih_reg[1]) |=> hold_o)
    else $error("Hold not entered after integrate/hold fell.");
endmodule

// ===== core/kspc_knock_ctrl.sv
// Control section of a two-channel knock signal processor: word decode, settings,
// diagnostic selection, sampling clock prescaler and integrate/hold sequencing.
// Assumes the serial pins, the oscillator and integrate/hold come from outside the core clock.

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Chip select low enables; otherwise clock ignored.
// - Capture data on every falling serial clock.
// - Eight bits, most significant bit first.
// - Split word into address and value fields.
// - Decode five word types into settings.
// - All words accepted while holding.
// - Integrate/hold rise starts integration.
// - Reset integrator, then integrate within 20 us.
// - Integrate/hold fall enters hold, freezes output.
// - Gain code shared by both gain stages.
// - Filter code shared by both bandpass filters.
// - Time constant is a 32-step code.
// - Exactly one sensor channel routed normally.
// - External test signals power down input amplifiers.
// - Antialias evaluation powers down output buffer.
// - Test multiplexer picks the diagnostic source.
// - Sampling clock is 200 kHz from input clock.
// - Prefix 00 loads filter, 10 loads gain.
// - Prefix 110 loads the time constant.
// - Prefix 111 loads channel and test bits.
// - Prefix 01 loads prescaler and output tristate.
module kspc_knock_ctrl
  import kspc_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       spi_sck_i,
  input  wire logic       spi_cs_n_i,
  input  wire logic       spi_mosi_i,
  input  wire logic       osc_clk_i,
  input  wire logic       int_hold_i,
  output logic [5:0]      gain_code_o,
  output logic [5:0]      bandpass_filter_code_o,
  output logic [4:0]      tc_code_o,
  output logic            channel_select_bit_o,
  output logic            chan0_enable_o,
  output logic            chan1_enable_o,
  output logic            amp_power_down_o,
  output logic            amp_out_hiz_o,
  output logic            out_buf_power_down_o,
  output kspc_pkg::kspc_src_t test_mux_sel_o,
  output logic [3:0]      prescaler_code_field_o,
  output logic            so_tristate_o,
  output logic            sc_clk_o,
  output logic            sc_tick_o,
  output logic            integ_reset_o,
  output logic            integ_run_o,
  output logic            hold_o,
  output logic            frame_error_o
);
  import kspc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.

  kspc_word_if wif ();

  logic [5:0]  gain_reg, gain_next;
  logic [5:0]  bpf_reg, bpf_next;
  logic [4:0]  tc_reg, tc_next;
  logic [4:0]  test_reg, test_next;
  logic [3:0]  pre_reg, pre_next;
  logic        z_reg, z_next;
  logic        err_reg, err_next;
  logic [2:0]  osc_reg, osc_next;
  logic [7:0]  div_reg, div_next;
  logic        sck_reg, sck_next;
  logic        tick_reg, tick_next;
  logic        pd_reg, pd_next;
  logic        hiz_reg, hiz_next;
  logic        obpd_reg, obpd_next;
  kspc_src_t   src_reg, src_next;
  kspc_kind_t  kind;
  logic [7:0]  ratio;
  logic        osc_rise;
  logic        hold_w;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial receiver and integrate/hold sequencer.

  // Receiver hands over only complete words.
  kspc_spi_rx u_rx (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .sck_i      (spi_sck_i),
    .cs_n_i     (spi_cs_n_i),
    .mosi_i     (spi_mosi_i),
    .wif        (wif.tx)
  );

  // Sequencer owns the integrator control lines.
  kspc_int_hold u_ih (
    .core_clk_i    (core_clk_i),
    .rst_n_i       (rst_n_i),
    .int_hold_i    (int_hold_i),
    .integ_reset_o (integ_reset_o),
    .integ_run_o   (integ_run_o),
    .hold_o        (hold_w)
  );

  assign hold_o = hold_w;

  ////////////////////////////////////////////////////////////////////////////////
  // Diagnostic decode.

  // Maps the three test bits above the channel bit onto a multiplexer source; unused codes read as normal run.
  function automatic kspc_src_t kspc_src(input logic [4:0] t);
    unique case (t[DIAG_LSB+SRC_MSB:DIAG_LSB])
      3'h1:    kspc_src = KSPC_SRC_INT_POS;
      3'h2:    kspc_src = KSPC_SRC_INT_NEG;
      3'h3:    kspc_src = KSPC_SRC_SCF;
      3'h4:    kspc_src = KSPC_SRC_GAIN;
      3'h5:    kspc_src = KSPC_SRC_AAF;
      default: kspc_src = KSPC_SRC_RUN;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Settings registers.

  assign kind = kspc_kind(wif.word);

  // Each word only touches the setting that its prefix names; words arrive in any
  // integrate/hold state, so a channel change between firings is not refused.
  always_comb begin
    gain_next = gain_reg;
    bpf_next  = bpf_reg;
    tc_next   = tc_reg;
    test_next = test_reg;
    pre_next  = pre_reg;
    z_next    = z_reg;
    err_next  = wif.frame_bad;
    if (wif.word_valid) begin
      unique case (kind)
        KSPC_WK_BPF: begin
          bpf_next = wif.word[V6_MSB:0];
        end
        KSPC_WK_GAIN: begin
          gain_next = wif.word[V6_MSB:0];
        end
        KSPC_WK_TC: begin
          tc_next = wif.word[V5_MSB:0];
        end
        KSPC_WK_TEST: begin
          test_next = wif.word[V5_MSB:0];
        end
        KSPC_WK_PRE: begin
          pre_next = wif.word[PRE_MSB:PRE_LSB];
          z_next   = wif.word[Z_BIT];
        end
      endcase
    end
  end

  // Registers of the settings.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gain_reg <= GAIN_RST;
      bpf_reg  <= BPF_RST;
      tc_reg   <= TC_RST;
      test_reg <= TEST_RST;
      pre_reg  <= PRE_RST;
      z_reg    <= Z_RST;
      err_reg  <= 1'b0;
    end else begin
      gain_reg <= gain_next;
      bpf_reg  <= bpf_next;
      tc_reg   <= tc_next;
      test_reg <= test_next;
      pre_reg  <= pre_next;
      z_reg    <= z_next;
      err_reg  <= err_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Diagnostic outputs.

  // Registered so the analog switches never see decode glitches.
  always_comb begin
    src_next  = kspc_src(test_reg);
    pd_next   = test_reg[DIAG_LSB+EXT_BIT];
    hiz_next  = test_reg[DIAG_LSB+EXT_BIT];
    obpd_next = (kspc_src(test_reg) == KSPC_SRC_AAF);
  end

  // Registers of the diagnostic outputs.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_reg  <= KSPC_SRC_RUN;
      pd_reg   <= 1'b0;
      hiz_reg  <= 1'b0;
      obpd_reg <= 1'b0;
    end else begin
      src_reg  <= src_next;
      pd_reg   <= pd_next;
      hiz_reg  <= hiz_next;
      obpd_reg <= obpd_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sampling clock prescaler.

  assign ratio    = kspc_ratio(pre_reg);
  assign osc_rise = osc_reg[1] & ~osc_reg[2];

  // Counts oscillator rises; one tick per sampling period, square wave high for the first half.
  always_comb begin
    osc_next  = {osc_reg[1:0], osc_clk_i};
    div_next  = div_reg;
    sck_next  = sck_reg;
    tick_next = 1'b0;
    if (osc_rise) begin
      if (div_reg >= ratio - 8'h01) begin
        div_next  = 8'h00;
        tick_next = 1'b1;
        sck_next  = 1'b1;
      end else begin
        div_next = div_reg + 8'h01;
        sck_next = (div_reg + 8'h01) < {1'b0, ratio[7:1]};
      end
    end
  end

  // Registers of the prescaler.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_reg  <= 3'h0;
      div_reg  <= 8'h00;
      sck_reg  <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      osc_reg  <= osc_next;
      div_reg  <= div_next;
      sck_reg  <= sck_next;
      tick_reg <= tick_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output assignments.

  assign gain_code_o            = gain_reg;
  assign bandpass_filter_code_o = bpf_reg;
  assign tc_code_o              = tc_reg;
  assign channel_select_bit_o   = test_reg[CHAN_BIT];
  assign chan0_enable_o         = ~test_reg[CHAN_BIT];
  assign chan1_enable_o         = test_reg[CHAN_BIT];
  assign amp_power_down_o       = pd_reg;
  assign amp_out_hiz_o          = hiz_reg;
  assign out_buf_power_down_o   = obpd_reg;
  assign test_mux_sel_o         = src_reg;
  assign prescaler_code_field_o = pre_reg;
  assign so_tristate_o          = z_reg;
  assign sc_clk_o               = sck_reg;
  assign sc_tick_o              = tick_reg;
  assign frame_error_o          = err_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  gain_load_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (wif.word_valid && wif.word[PFX_MSB:PFX_LSB] == PFX_GAIN) |=> gain_code_o == $past(wif.word[V6_MSB:0]))
    else $error("Gain word not applied.");

  bpf_keep_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !$stable(bpf_reg) |-> $past(wif.word_valid) && $past(wif.word[PFX_MSB:PFX_LSB]) == PFX_BPF)
    else $error("Filter code changed without a filter word.");

  tc_load_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (wif.word_valid && wif.word[PFX_MSB:SUB_BIT] == 3'h6) |=> tc_code_o == $past(wif.word[V5_MSB:0]))
    else $error("Time-constant word not applied.");

  chan_one_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    chan0_enable_o != chan1_enable_o)
    else $error("Channel multiplexer not one-hot.");

  amp_hiz_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (wif.word_valid && kind == KSPC_WK_TEST && wif.word[DIAG_LSB+EXT_BIT]) |=> ##1 (amp_power_down_o && amp_out_hiz_o))
    else $error("Input amplifiers not powered down for external test.");

  obuf_pd_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (test_mux_sel_o == KSPC_SRC_AAF) |-> out_buf_power_down_o)
    else $error("Output buffer active while antialias output is selected.");

  pre_load_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (wif.word_valid && kind == KSPC_WK_PRE) |=> so_tristate_o == $past(wif.word[Z_BIT]))
    else $error("Output tristate bit not applied.");

  tick_period_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    sc_tick_o |-> $past(div_reg) >= ratio - 8'h01 || $changed(pre_reg))
    else $error("Sampling tick before the division ratio.");
endmodule

// ===== dv/kspc_host_model.sv
// Host model that drives the serial pins of the knock processor control.
// Assumes the core clock paces every pin change; all waits are in core cycles.
module kspc_host_model (
  input  wire logic clk_i,
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      mosi_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle pins: serial clock still and low, device deselected.
  initial begin
    sck_o  = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // Sends n bits of w, top bit first; with sel low chip select stays high.
  task automatic frame(input logic [15:0] w, input int n, input logic sel);
    @(posedge clk_i);
    cs_n_o <= ~sel;
    repeat (24) @(posedge clk_i);
    for (int i = n - 1; i >= 0; i--) begin
      mosi_o <= w[i];
      sck_o  <= 1'b1;
      repeat (16) @(posedge clk_i);
      sck_o  <= 1'b0;
      repeat (16) @(posedge clk_i);
    end
    repeat (8) @(posedge clk_i); // Last falling clock to deselect is held beyond its minimum.
    cs_n_o <= 1'b1;
    mosi_o <= ~mosi_o; // Released data line shows no stale value.
    repeat (60) @(posedge clk_i);
  endtask
endmodule

// ===== dv/tb_knock_processor_spi_control.sv
// Self-checking bench for the knock processor control section.
// Assumes the host model drives the serial pins and a 20 MHz oscillator feeds the prescaler.
module tb_knock_processor_spi_control;
  timeunit 1ns;
  timeprecision 1ps;
  import kspc_pkg::*;

  logic       core_clk, rst_n, osc_clk, int_hold, sck, cs_n, mosi;
  logic [5:0] gain, bandpass_filter, e_bpf, e_gain;
  logic [4:0] tc, e_tc;
  logic [3:0] pre, e_pre;
  logic       ch, en0, en1, apd, hiz, obpd, so_z, tick, scc, ireset, irun, hold, ferr, e_z, e_ch, e_ext;
  kspc_src_t  msel, e_src;
  int         err_count, checks, fe_cnt, n;

  kspc_knock_ctrl uut (.core_clk_i(core_clk), .rst_n_i(rst_n), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
    .spi_mosi_i(mosi), .osc_clk_i(osc_clk), .int_hold_i(int_hold), .gain_code_o(gain),
    .bandpass_filter_code_o(bandpass_filter), .tc_code_o(tc), .channel_select_bit_o(ch), .chan0_enable_o(en0),
    .chan1_enable_o(en1), .amp_power_down_o(apd), .amp_out_hiz_o(hiz), .out_buf_power_down_o(obpd),
    .test_mux_sel_o(msel), .prescaler_code_field_o(pre), .so_tristate_o(so_z), .sc_clk_o(scc),
    .sc_tick_o(tick), .integ_reset_o(ireset), .integ_run_o(irun), .hold_o(hold), .frame_error_o(ferr));
  kspc_host_model host (.clk_i(core_clk), .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi));

  ////////////////////////////////////////////////////////////////////////////////
  // Core clock at 250 MHz and an unrelated 20 MHz oscillator.
  always #2 core_clk = ~core_clk;
  always #25 osc_clk = ~osc_clk;

  // Counts frame error pulses.
  always @(posedge core_clk) if (ferr === 1'b1) fe_cnt++;

  // Compares one value and reports a mismatch at once.
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Compares every setting with the expected state.
  task automatic check_all(input string msg);
    @(negedge core_clk);
    cmp(8'(bandpass_filter), 8'(e_bpf), msg);
    cmp(8'(gain), 8'(e_gain), msg);
    cmp(8'(tc), 8'(e_tc), msg);
    cmp(8'(pre), 8'(e_pre), msg);
    cmp(8'(so_z), 8'(e_z), msg);
    cmp(8'({ch, en1, en0}), 8'({e_ch, e_ch, ~e_ch}), msg);
    cmp(8'({apd, hiz}), 8'({e_ext, e_ext}), msg);
    cmp(8'(obpd), 8'(e_src == KSPC_SRC_AAF), msg);
    cmp(8'(msel), 8'(e_src), msg);
  endtask

  // Sends one word, updates the expected settings from its prefix, then checks.
  task automatic word(input logic [7:0] w);
    host.frame(16'(w), 8, 1'b1);
    case (w[7:6])
      2'h0: e_bpf = w[5:0];
      2'h1: begin
        e_pre = w[4:1];
        e_z   = w[0];
      end
      2'h2: e_gain = w[5:0];
      default: if (w[5]) begin
        e_ch  = w[0];
        e_ext = w[4];
        e_src = (w[3:1] >= 3'h1 && w[3:1] <= 3'h5) ? kspc_src_t'(w[3:1]) : KSPC_SRC_RUN;
      end else e_tc = w[4:0];
    endcase
    check_all($sformatf("word %h", w));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Each prefix loaded with boundary values; other settings must not move.
  task automatic t_words();
    word(8'h3f);
    word(8'hbf);
    word(8'hdf);
    word(8'h4e);
    word(8'he1);
    word(8'h00);
    word(8'hc0);
    $display("test words done");
  endtask

  // Every diagnostic code with and without external test signals.
  task automatic t_diag();
    for (int d = 0; d < 16; d++) word(8'he0 | 8'(d << 1) | 8'(d[1]));
    $display("test diag done");
  endtask

  // Short, long and deselected frames are dropped.
  task automatic t_bad();
    host.frame(16'h0015, 7, 1'b1);
    check_all("seven bits");
    cmp(8'(fe_cnt), 8'h01, "short frame error");
    host.frame(16'h01bf, 9, 1'b1);
    check_all("nine bits");
    cmp(8'(fe_cnt), 8'h02, "long frame error");
    host.frame(16'h00bf, 8, 1'b0);
    check_all("deselected");
    cmp(8'(fe_cnt), 8'h02, "deselected error");
    $display("test bad frames done");
  endtask

  // Integrate, reset phase length, then hold.
  task automatic t_integ();
    repeat (2100) @(posedge core_clk);
    int_hold <= 1'b1;
    n = 0;
    while (ireset !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    cmp(8'({ireset, hold}), 8'h02, "reset phase");
    n = 0;
    while (irun !== 1'b1 && n < 6000) begin
      @(negedge core_clk);
      n++;
    end
    cmp(8'(n >= INT_RESET_CYC - 3 && n <= INT_RESET_CYC + 3), 8'h01, "reset length");
    cmp(8'({ireset, hold}), 8'h00, "integrating");
    @(posedge core_clk);
    int_hold <= 1'b0;
    repeat (8) @(negedge core_clk);
    cmp(8'({irun, hold}), 8'h01, "hold");
    $display("test integrate done");
  endtask

  // Waits for a sampling tick, then counts core cycles and high clock cycles up to the next tick.
  task automatic tick_gap(output int gap, output int high);
    gap = 0;
    while (tick !== 1'b1 && gap < 3000) begin
      @(negedge core_clk);
      gap++;
    end
    gap  = 1;
    high = 0;
    @(negedge core_clk);
    high += int'(scc === 1'b1);
    while (tick !== 1'b1 && gap < 3000) begin
      @(negedge core_clk);
      gap++;
      high += int'(scc === 1'b1);
    end
  endtask

  // Sampling period and clock half period with prescaler codes 7 and 0 on a 20 MHz oscillator.
  task automatic t_presc();
    int hi;
    word(8'h4e);
    tick_gap(n, hi);
    cmp(8'(n >= 1248 && n <= 1252), 8'h01, "tick period");
    cmp(8'(hi >= 622 && hi <= 628), 8'h01, "clock high");
    word(8'h40);
    tick_gap(n, hi);
    cmp(8'(n >= 248 && n <= 252), 8'h01, "code 0 period");
    cmp(8'(hi >= 122 && hi <= 128), 8'h01, "code 0 clock high");
    $display("test prescaler done period %0d", n);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("counts: checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog well beyond the expected run of about 15000 cycles.
  initial begin
    #200us;
    err_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_sim();
  end

  // Reset, then the scenarios in order.
  initial begin
    {core_clk, rst_n, osc_clk, int_hold} = 4'h0;
    {err_count, checks, fe_cnt} = '0;
    {e_bpf, e_gain, e_tc, e_pre, e_z, e_ch, e_ext} = {BPF_RST, GAIN_RST, TC_RST, PRE_RST, Z_RST, 2'h0};
    e_src = KSPC_SRC_RUN;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    check_all("reset");
    cmp(8'(hold), 8'h01, "reset hold");
    t_words();
    t_diag();
    t_bad();
    t_integ();
    t_presc();
    end_sim();
  end
endmodule
